/* File: core/dac_channel.sv */
// one dac channel: input register, dac register and power-down state
module dac_channel #(
  parameter int RES = 12,
  parameter logic [RES-1:0] POR_CODE = '0,
  parameter bit POR_PD = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_input,
  input wire logic update,
  input wire logic power_down,
  input wire logic power_up,
  input wire logic [RES-1:0] code_in,
  output logic [RES-1:0] input_q,
  output logic [RES-1:0] dac_q,
  output logic pd_q
);
  always_ff @(posedge clk) begin
    if (rst) begin
      input_q <= POR_CODE;
    end else if (wr_input) begin
      input_q <= code_in;
    end
  end

  // a write in the same cycle as an update goes straight through
  always_ff @(posedge clk) begin
    if (rst) begin
      dac_q <= POR_CODE;
    end else if (update) begin
      dac_q <= wr_input ? code_in : input_q;
    end
  end

  // power-up wins so a held-low update pin cannot be overridden
  always_ff @(posedge clk) begin
    if (rst) begin
      pd_q <= POR_PD;
    end else if (power_up) begin
      pd_q <= 1'b0;
    end else if (power_down) begin
      pd_q <= 1'b1;
    end
  end
endmodule

/* File: core/dac_ctrl_pkg.sv */
// shared constants and types for the quad dac serial control block
package dac_ctrl_pkg;
  localparam int NUM_CH = 4;
  localparam int RES_DEFAULT = 12;
  localparam int WORD_W = 24;
  localparam int CMD_MSB = 23;
  localparam int CMD_LSB = 20;
  localparam int CH_MSB = 19;
  localparam int CH_LSB = 16;
  localparam int DATA_MSB = 15;

  localparam logic [6:0] GLOBAL_ADDR = 7'h73;
  localparam logic [6:0] SLAVE_ADDR_DEFAULT = 7'h10;

  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [1:0] DATA_BYTES = 2'h3;
  localparam logic [1:0] LAST_BYTE = 2'h2;

  localparam logic [3:0] CMD_WRITE = 4'h0;
  localparam logic [3:0] CMD_UPDATE = 4'h1;
  localparam logic [3:0] CMD_WRITE_UPDATE_ALL = 4'h2;
  localparam logic [3:0] CMD_WRITE_UPDATE = 4'h3;
  localparam logic [3:0] CMD_POWER_DOWN_CH = 4'h4;
  localparam logic [3:0] CMD_POWER_DOWN_CHIP = 4'h5;
  localparam logic [3:0] CMD_SEL_INT_REF = 4'h6;
  localparam logic [3:0] CMD_SEL_EXT_REF = 4'h7;
  localparam logic [3:0] CMD_NOP = 4'hF;
  localparam logic [3:0] CH_ALL = 4'hF;

  localparam int POR_ZERO = 0;
  localparam int POR_MID_INT = 1;
  localparam int POR_MID_EXT = 2;
  localparam int POR_HIZ = 3;

  typedef enum logic [4:0] {
    RX_IDLE = 5'b00001,
    RX_ADDR = 5'b00010,
    RX_DATA = 5'b00100,
    RX_ACK = 5'b01000,
    RX_IGNORE = 5'b10000
  } rx_state_e;
endpackage

/* File: core/quad_dac_i2c_control.sv */
// write-only two-wire slave controlling four dac channels
// Summary of operation
// - update pin falling after a full write copies all input registers to dac registers.
// - update pin low without a complete four-byte write leaves dac outputs alone.
// - update pin held low powers up every dac channel.
// - serial power-down commands are ignored while update pin is low.
// - serial data bits are taken on rising edges of the serial clock.
// - data line released while shifting; pulled low only during acknowledge clocks.
// - receive-only slave; read address bytes get no acknowledge.
// - data falling while clock high is start; receiver begins a new transaction.
// - zero-scale option resets input and dac registers to code zero.
// - mid-scale options load mid-scale; internal-reference variants start on internal reference.
// - external-reference mid-scale option starts on external reference at mid-scale.
// - high-impedance option starts internal reference, channels down, registers mid-scale.
// - dac code k gives output k over two to N of the reference span.
// - acknowledge own or global write address, then three bytes; execute after third.
// - data bytes beyond the third are not acknowledged.
// - first byte command then channel; next two bytes code msb-first, padding after.
// - command set and channel codes zero to three, all ones meaning all.
module quad_dac_i2c_control #(
  parameter int RES = dac_ctrl_pkg::RES_DEFAULT,
  parameter int POR_OPTION = dac_ctrl_pkg::POR_ZERO,
  parameter logic [6:0] SLAVE_ADDR = dac_ctrl_pkg::SLAVE_ADDR_DEFAULT
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic async_update_n,
  output logic sda_pull,
  output logic sda_oe_n,
  output logic [RES-1:0] code_a,
  output logic [RES-1:0] code_b,
  output logic [RES-1:0] code_c,
  output logic [RES-1:0] code_d,
  output logic [dac_ctrl_pkg::NUM_CH-1:0] chan_powered_down,
  output logic ext_ref_sel,
  output logic ref_powered_down,
  output logic transfer_complete
);
  localparam int NCH = dac_ctrl_pkg::NUM_CH;
  localparam logic [RES-1:0] MID_CODE = {1'b1, {(RES-1){1'b0}}};
  localparam logic [RES-1:0] POR_CODE = (POR_OPTION == dac_ctrl_pkg::POR_ZERO) ? '0 : MID_CODE;
  localparam bit POR_EXT = (POR_OPTION == dac_ctrl_pkg::POR_MID_EXT);
  localparam bit POR_PD = (POR_OPTION == dac_ctrl_pkg::POR_HIZ);

  if (!(RES == 8 || RES == 10 || RES == 12)) begin : g_bad_res
    $error("resolution must be 8, 10 or 12 bits");
  end
  if (POR_OPTION < dac_ctrl_pkg::POR_ZERO || POR_OPTION > dac_ctrl_pkg::POR_HIZ) begin : g_bad_por
    $error("unknown power-on option");
  end

  logic scl_s;
  logic sda_s;
  logic upd_n_s;
  logic scl_prev_q;
  logic sda_prev_q;
  logic upd_prev_q;

  dac_ctrl_pkg::rx_state_e state_q;
  dac_ctrl_pkg::rx_state_e state_d;
  logic [3:0] bit_cnt_q;
  logic [1:0] byte_cnt_q;
  logic [7:0] shift_q;
  logic [dac_ctrl_pkg::WORD_W-1:0] word_q;
  logic ack_go_q;
  logic exec_arm_q;
  logic exec_q;
  logic full_q;
  logic sda_oe_n_q;
  logic sda_pull_q;
  logic ext_ref_q;
  logic ref_pd_q;

  // pins are asynchronous to ref_clk
  sync_bit #(.RST_VAL(1'b1)) u_sync_scl (
    .clk(ref_clk),
    .rst(rst),
    .d(scl),
    .q(scl_s)
  );
  sync_bit #(.RST_VAL(1'b1)) u_sync_sda (
    .clk(ref_clk),
    .rst(rst),
    .d(sda),
    .q(sda_s)
  );
  sync_bit #(.RST_VAL(1'b1)) u_sync_upd (
    .clk(ref_clk),
    .rst(rst),
    .d(async_update_n),
    .q(upd_n_s)
  );

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
      upd_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
      upd_prev_q <= upd_n_s;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic upd_low;
  logic upd_fall;
  logic bits_done;
  logic addr_ok;
  logic data_room;

  assign scl_rise = scl_s & ~scl_prev_q;
  assign scl_fall = ~scl_s & scl_prev_q;
  assign start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  assign stop_det = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
  assign upd_low = ~upd_n_s;
  assign upd_fall = upd_prev_q & ~upd_n_s;
  assign bits_done = scl_fall && (bit_cnt_q == dac_ctrl_pkg::BITS_PER_BYTE);
  // read bit set or foreign address: no acknowledge
  assign addr_ok = ((shift_q[7:1] == SLAVE_ADDR) || (shift_q[7:1] == dac_ctrl_pkg::GLOBAL_ADDR))
                   && !shift_q[0];
  assign data_room = (byte_cnt_q < dac_ctrl_pkg::DATA_BYTES);

  always_comb begin
    state_d = state_q;
    if (stop_det) begin
      state_d = dac_ctrl_pkg::RX_IDLE;
    end else if (start_det) begin
      state_d = dac_ctrl_pkg::RX_ADDR;
    end else begin
      case (state_q)
        dac_ctrl_pkg::RX_ADDR: begin
          if (bits_done) begin
            state_d = dac_ctrl_pkg::RX_ACK;
          end
        end
        dac_ctrl_pkg::RX_DATA: begin
          if (bits_done) begin
            state_d = dac_ctrl_pkg::RX_ACK;
          end
        end
        dac_ctrl_pkg::RX_ACK: begin
          if (scl_fall) begin
            state_d = ack_go_q ? dac_ctrl_pkg::RX_DATA : dac_ctrl_pkg::RX_IGNORE;
          end
        end
        default: begin
          state_d = state_q;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= dac_ctrl_pkg::RX_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  logic shifting;
  assign shifting = (state_q == dac_ctrl_pkg::RX_ADDR) || (state_q == dac_ctrl_pkg::RX_DATA);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bit_cnt_q <= '0;
    end else if (start_det || stop_det) begin
      bit_cnt_q <= '0;
    end else if (state_q == dac_ctrl_pkg::RX_ACK && scl_fall) begin
      bit_cnt_q <= '0;
    end else if (shifting && scl_rise && bit_cnt_q != dac_ctrl_pkg::BITS_PER_BYTE) begin
      bit_cnt_q <= bit_cnt_q + 4'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      shift_q <= '0;
    end else if (shifting && scl_rise) begin
      shift_q <= {shift_q[6:0], sda_s};
    end
  end

  // only the first three data bytes land in the command word
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      word_q <= '0;
    end else if (state_q == dac_ctrl_pkg::RX_DATA && scl_rise && data_room) begin
      word_q <= {word_q[dac_ctrl_pkg::WORD_W-2:0], sda_s};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      byte_cnt_q <= '0;
    end else if (start_det) begin
      byte_cnt_q <= '0;
    end else if (state_q == dac_ctrl_pkg::RX_DATA && bits_done && data_room) begin
      byte_cnt_q <= byte_cnt_q + 2'h1;
    end
  end

  // after a nack of extra data the receiver keeps nacking until the next stop or start
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ack_go_q <= 1'b0;
    end else if (bits_done && state_q == dac_ctrl_pkg::RX_ADDR) begin
      ack_go_q <= addr_ok;
    end else if (bits_done && state_q == dac_ctrl_pkg::RX_DATA) begin
      ack_go_q <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      exec_arm_q <= 1'b0;
    end else if (start_det || stop_det) begin
      exec_arm_q <= 1'b0;
    end else if (bits_done) begin
      exec_arm_q <= (state_q == dac_ctrl_pkg::RX_DATA) && (byte_cnt_q == dac_ctrl_pkg::LAST_BYTE);
    end
  end

  // the word runs at the fall of the ninth clock of the third byte
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      exec_q <= 1'b0;
    end else begin
      exec_q <= (state_q == dac_ctrl_pkg::RX_ACK) && scl_fall && exec_arm_q && !stop_det;
    end
  end

  // pulled low only between the eighth and ninth falling clock edges
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sda_oe_n_q <= 1'b1;
    end else if (start_det || stop_det) begin
      sda_oe_n_q <= 1'b1;
    end else if (bits_done && state_q == dac_ctrl_pkg::RX_ADDR) begin
      sda_oe_n_q <= !addr_ok;
    end else if (bits_done && state_q == dac_ctrl_pkg::RX_DATA) begin
      sda_oe_n_q <= !data_room;
    end else if (state_q == dac_ctrl_pkg::RX_ACK && scl_fall) begin
      sda_oe_n_q <= 1'b1;
    end
  end

  // open drain: the driven value is always low
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sda_pull_q <= 1'b0;
    end else begin
      sda_pull_q <= 1'b0;
    end
  end

  logic [3:0] cmd;
  logic [3:0] chan;
  logic [RES-1:0] code_in;
  logic async_update_n_update;
  assign cmd = word_q[dac_ctrl_pkg::CMD_MSB:dac_ctrl_pkg::CMD_LSB];
  assign chan = word_q[dac_ctrl_pkg::CH_MSB:dac_ctrl_pkg::CH_LSB];
  assign code_in = word_q[dac_ctrl_pkg::DATA_MSB -: RES];
  // needs a finished write since the last pin-driven update
  assign async_update_n_update = upd_fall && full_q;

  // a new write in the same cycle as a pin update keeps the flag set
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      full_q <= 1'b0;
    end else if (exec_q) begin
      full_q <= 1'b1;
    end else if (async_update_n_update) begin
      full_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ext_ref_q <= POR_EXT;
    end else if (exec_q && cmd == dac_ctrl_pkg::CMD_SEL_INT_REF) begin
      ext_ref_q <= 1'b0;
    end else if (exec_q && cmd == dac_ctrl_pkg::CMD_SEL_EXT_REF) begin
      ext_ref_q <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ref_pd_q <= POR_EXT;
    end else if (exec_q && cmd == dac_ctrl_pkg::CMD_SEL_INT_REF) begin
      ref_pd_q <= 1'b0;
    end else if (exec_q && cmd == dac_ctrl_pkg::CMD_SEL_EXT_REF) begin
      ref_pd_q <= 1'b1;
    end else if (exec_q && cmd == dac_ctrl_pkg::CMD_POWER_DOWN_CHIP && !upd_low) begin
      ref_pd_q <= 1'b1;
    end
  end

  logic [RES-1:0] dac_code [NCH];
  logic [NCH-1:0] pd_bits;

  for (genvar i = 0; i < NCH; i++) begin : g_ch
    logic sel;
    logic is_write;
    logic wr_input;
    logic update;
    logic power_down;
    logic power_up;
    // reserved channel codes select nothing
    assign sel = (chan == 4'(i)) || (chan == dac_ctrl_pkg::CH_ALL);
    assign is_write = (cmd == dac_ctrl_pkg::CMD_WRITE) || (cmd == dac_ctrl_pkg::CMD_WRITE_UPDATE_ALL)
                      || (cmd == dac_ctrl_pkg::CMD_WRITE_UPDATE);
    assign wr_input = exec_q && sel && is_write;
    assign update = (exec_q && sel && (cmd == dac_ctrl_pkg::CMD_UPDATE || cmd == dac_ctrl_pkg::CMD_WRITE_UPDATE))
                    || (exec_q && cmd == dac_ctrl_pkg::CMD_WRITE_UPDATE_ALL)
                    || async_update_n_update;
    assign power_up = update || upd_low;
    assign power_down = exec_q && !upd_low && ((sel && cmd == dac_ctrl_pkg::CMD_POWER_DOWN_CH)
                        || cmd == dac_ctrl_pkg::CMD_POWER_DOWN_CHIP);

    dac_channel #(
      .RES(RES),
      .POR_CODE(POR_CODE),
      .POR_PD(POR_PD)
    ) u_ch (
      .clk(ref_clk),
      .rst(rst),
      .wr_input(wr_input),
      .update(update),
      .power_down(power_down),
      .power_up(power_up),
      .code_in(code_in),
      .input_q(),
      .dac_q(dac_code[i]),
      .pd_q(pd_bits[i])
    );
  end

  // codes leave as k; the analog stage scales by the reference span over 2^RES
  assign code_a = dac_code[0];
  assign code_b = dac_code[1];
  assign code_c = dac_code[2];
  assign code_d = dac_code[3];
  assign chan_powered_down = pd_bits;
  assign ext_ref_sel = ext_ref_q;
  assign ref_powered_down = ref_pd_q;
  assign transfer_complete = full_q;
  assign sda_oe_n = sda_oe_n_q;
  assign sda_pull = sda_pull_q;
endmodule

/* File: core/sync_bit.sv */
// two-flop synchroniser for one asynchronous level
module sync_bit #(
  parameter bit RST_VAL = 1'b1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic d,
  output logic q
);
  logic stage1_q;

  // stage1_q is read by the second flop only
  always_ff @(posedge clk) begin
    if (rst) begin
      stage1_q <= RST_VAL;
      q <= RST_VAL;
    end else begin
      stage1_q <= d;
      q <= stage1_q;
    end
  end
endmodule

/* File: dv/i2c_master_model.sv */
// two-wire bus master model writing words into the dac block
module i2c_master_model (
  input wire logic lk_clk,
  input wire logic sda_w,
  output logic scl,
  output logic sda_m
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    scl = 1'h1;
    sda_m = 1'h1;
  end
  // works from idle and as a repeated start after an ack
  task automatic start();
    @(posedge lk_clk) sda_m = 1'h1;
    @(posedge lk_clk) scl = 1'h1;
    @(posedge lk_clk) sda_m = 1'h0;
    @(posedge lk_clk) scl = 1'h0;
  endtask
  task automatic stop();
    @(posedge lk_clk) sda_m = 1'h0;
    @(posedge lk_clk) scl = 1'h1;
    @(posedge lk_clk) sda_m = 1'h1;
  endtask
  task automatic bit_io(input logic b, output logic rd);
    @(posedge lk_clk) sda_m = b;
    @(posedge lk_clk) scl = 1'h1;
    @(posedge lk_clk) rd = sda_w;
    scl = 1'h0;
  endtask
  task automatic byte_out(input logic [7:0] v, output logic ack);
    logic rd;
    for (int i = 7; i >= 0; i--) bit_io(v[i], rd);
    bit_io(1'h1, ack);
  endtask
endmodule

/* File: dv/quad_dac_i2c_control_properties.sv */
// port-level assertions for the quad dac serial control block
module quad_dac_i2c_control_properties #(
  parameter int RES = 12
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic async_update_n,
  input wire logic sda_pull,
  input wire logic sda_oe_n,
  input wire logic [RES-1:0] code_a,
  input wire logic [RES-1:0] code_b,
  input wire logic [RES-1:0] code_c,
  input wire logic [RES-1:0] code_d,
  input wire logic [dac_ctrl_pkg::NUM_CH-1:0] chan_powered_down,
  input wire logic ext_ref_sel,
  input wire logic ref_powered_down,
  input wire logic transfer_complete
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // acknowledge lasts far beyond eight cycles at the bench's bus rate
  sequence s_ack_hold;
    (!sda_oe_n) [*8];
  endsequence
  // pin low long enough to pass the synchroniser
  sequence s_pin_low;
    (!async_update_n) [*6];
  endsequence
  property p_pull_low;
    !sda_oe_n |-> !sda_pull;
  endproperty
  property p_ack_start;
    $fell(sda_oe_n) |-> !scl ##1 s_ack_hold;
  endproperty
  property p_ack_release;
    $rose(sda_oe_n) |-> !scl;
  endproperty
  property p_codes_need_word;
    !$stable({code_a, code_b, code_c, code_d}) |-> transfer_complete || $past(transfer_complete);
  endproperty
  property p_tc_clear;
    $fell(transfer_complete) |-> $past(async_update_n, 2) == 1'h0;
  endproperty
  property p_pin_up;
    s_pin_low |-> chan_powered_down == '0;
  endproperty
  property p_exec_after_ack;
    $rose(transfer_complete) |-> sda_oe_n && $past(sda_oe_n);
  endproperty
  property p_ext_ref;
    ext_ref_sel |-> ref_powered_down;
  endproperty
  a_pull_low: assert property (p_pull_low) else $error("sda driven high");
  a_ack_start: assert property (p_ack_start) else $error("ack not held");
  a_ack_release: assert property (p_ack_release) else $error("ack released late");
  a_codes_need_word: assert property (p_codes_need_word) else $error("code moved without word");
  a_tc_clear: assert property (p_tc_clear) else $error("complete flag lost");
  a_pin_up: assert property (p_pin_up) else $error("channel down while pin low");
  a_exec_after_ack: assert property (p_exec_after_ack) else $error("word ran before ack end");
  a_ext_ref: assert property (p_ext_ref) else $error("ext ref with ref up");
endmodule

/* File: dv/testbench.sv */
// self-checking bench for the quad dac serial control block
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int RES = 12;
  localparam logic [6:0] ADDR = 7'h2A;
  localparam logic [RES-1:0] MID = {1'h1, {(RES-1){1'h0}}};
  logic ref_clk = 1'h0;
  logic lk_clk = 1'h0;
  logic rst = 1'h1;
  logic async_update_n = 1'h1;
  logic scl, sda_m, sda_pull, sda_oe_n, ext, rpd, tc;
  logic [RES-1:0] code_a, code_b, code_c, code_d;
  logic [3:0] pd;
  logic [RES-1:0] in_m[4];
  logic [RES-1:0] dac_m[4];
  logic [3:0] pd_m;
  logic ext_m, rpd_m;
  int failures = 0;
  int tests_run = 0;
  int seed = 78342;
  wire sda_w = sda_m & (sda_oe_n | sda_pull);
  wire [4*RES-1:0] codes = {code_d, code_c, code_b, code_a};
  always #2.5 ref_clk = ~ref_clk;
  // link clock phase offset keeps the domains unrelated
  initial #7 forever #24 lk_clk = ~lk_clk;
  quad_dac_i2c_control #(.RES(RES), .POR_OPTION(dac_ctrl_pkg::POR_HIZ), .SLAVE_ADDR(ADDR)) i_quad_dac_i2c_control (
    .ref_clk(ref_clk), .rst(rst), .scl(scl), .sda(sda_w), .async_update_n(async_update_n),
    .sda_pull(sda_pull), .sda_oe_n(sda_oe_n), .code_a(code_a), .code_b(code_b), .code_c(code_c),
    .code_d(code_d), .chan_powered_down(pd), .ext_ref_sel(ext), .ref_powered_down(rpd),
    .transfer_complete(tc));
  // other power-on options share the bus at address 7'h5D; of the bench's addresses they answer only the global one
  wire [RES-1:0] por_a[3];
  wire [3:0] por_pd[3];
  wire [2:0] por_ext, por_rpd;
  for (genvar k = 0; k < 3; k++) begin : g_por
    quad_dac_i2c_control #(.RES(RES), .POR_OPTION(k), .SLAVE_ADDR(7'h5D)) i_quad_dac_i2c_control (
      .ref_clk(ref_clk), .rst(rst), .scl(scl), .sda(sda_w), .async_update_n(async_update_n),
      .sda_pull(), .sda_oe_n(), .code_a(por_a[k]), .code_b(), .code_c(), .code_d(),
      .chan_powered_down(por_pd[k]), .ext_ref_sel(por_ext[k]), .ref_powered_down(por_rpd[k]),
      .transfer_complete());
  end
  i2c_master_model master (.lk_clk(lk_clk), .sda_w(sda_w), .scl(scl), .sda_m(sda_m));
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  function automatic void apply(input logic [3:0] c, input logic [3:0] n, input logic [RES-1:0] k,
                                input logic low);
    logic [3:0] m;
    m = (n == 4'hF) ? 4'hF : 4'h1 << n[1:0];
    for (int i = 0; i < 4; i++) begin
      if (m[i] && c inside {4'h0, 4'h2, 4'h3}) in_m[i] = k;
      if ((m[i] && c inside {4'h1, 4'h3}) || c == 4'h2) begin
        dac_m[i] = in_m[i];
        pd_m[i] = 1'h0;
      end
      if (!low && ((m[i] && c == 4'h4) || c == 4'h5)) pd_m[i] = 1'h1;
    end
    if ((c == 4'h5 && !low) || c == 4'h7) rpd_m = 1'h1;
    if (c == 4'h6) rpd_m = 1'h0;
    if (c[3:1] == 3'h3) ext_m = c[0];
  endfunction
  task automatic check_all();
    for (int i = 0; i < 4; i++) chk("code", codes[i*RES +: RES], dac_m[i]);
    chk("pd", pd, pd_m);
    chk("ext", ext, ext_m);
    chk("rpd", rpd, rpd_m);
  endtask
  // byte slot 4 is an extra byte beyond the word
  task automatic xfer(input logic [7:0] a, input logic [23:0] w, input int n, input logic stp,
                      output logic [4:0] ak);
    logic [31:0] f;
    f = {a, w};
    ak = '1;
    master.start();
    for (int i = 0; i <= n; i++) master.byte_out(i == 4 ? 8'h5A : f[31-8*i -: 8], ak[i]);
    if (stp) master.stop();
    repeat (12) @(negedge ref_clk);
  endtask
  task automatic word(input logic [3:0] c, input logic [3:0] n, input logic [RES-1:0] k, input logic low);
    logic [4:0] ak;
    xfer({ADDR, 1'h0}, {c, n, k, 4'($random(seed))}, 3, 1'h1, ak);
    chk("ack", ak, 5'h10);
    apply(c, n, k, low);
    check_all();
  endtask
  task automatic pin(input logic v);
    @(negedge ref_clk) async_update_n = v;
    repeat (12) @(negedge ref_clk);
  endtask
  initial begin
    #450000;
    failures++;
    give_verdict();
  end
  initial begin
    logic [31:0] r;
    logic [4:0] ak;
    in_m = '{MID, MID, MID, MID};
    dac_m = in_m;
    pd_m = 4'hF;
    ext_m = 1'h0;
    rpd_m = 1'h0;
    repeat (2) @(negedge ref_clk);
    rst = 1'h0;
    repeat (6) @(negedge ref_clk);
    check_all();
    chk("tc", tc, 1'h0);
    for (int k = 0; k < 3; k++) begin
      chk("por code", por_a[k], (k == dac_ctrl_pkg::POR_ZERO) ? '0 : MID);
      chk("por pd", por_pd[k], 4'h0);
      chk("por ext", por_ext[k], k == dac_ctrl_pkg::POR_MID_EXT);
      chk("por rpd", por_rpd[k], k == dac_ctrl_pkg::POR_MID_EXT);
    end
    xfer({ADDR, 1'h1}, 24'h3F0FFF, 3, 1'h1, ak);
    chk("ack", ak, 5'h1F);
    xfer({7'h11, 1'h0}, 24'h3F0FFF, 3, 1'h1, ak);
    chk("ack", ak, 5'h1F);
    check_all();
    xfer({dac_ctrl_pkg::GLOBAL_ADDR, 1'h0}, 24'h30ABC0, 4, 1'h1, ak);
    chk("ack", ak, 5'h10);
    apply(4'h3, 4'h0, 12'hABC, 1'h0);
    check_all();
    xfer({ADDR, 1'h0}, 24'h31FFF0, 2, 1'h1, ak);
    chk("ack", ak, 5'h18);
    check_all();
    xfer({ADDR, 1'h0}, 24'h321230, 1, 1'h0, ak);
    word(4'h3, 4'h2, 12'h0F1, 1'h0);
    for (int c = 0; c < 16; c++) begin
      r = $random(seed);
      word(4'(c), r[6] ? 4'hF : {2'h0, r[5:4]}, r[19:8], 1'h0);
    end
    repeat (12) begin
      r = $random(seed);
      word(r[3:0], r[6] ? 4'hF : {2'h0, r[5:4]}, r[19:8], 1'h0);
    end
    word(4'h0, 4'hF, 12'h5A5, 1'h0);
    word(4'h4, 4'hF, 12'h000, 1'h0);
    chk("tc", tc, 1'h1);
    pin(1'h0);
    dac_m = in_m;
    pd_m = 4'h0;
    check_all();
    chk("tc", tc, 1'h0);
    word(4'h4, 4'h2, 12'h000, 1'h1);
    // a held-low pin must not pass a new input code through
    word(4'h0, 4'h1, 12'h3C3, 1'h1);
    pin(1'h1);
    check_all();
    chk("tc", tc, 1'h1);
    pin(1'h0);
    dac_m = in_m;
    check_all();
    pin(1'h1);
    give_verdict();
  end
endmodule
bind quad_dac_i2c_control quad_dac_i2c_control_properties #(.RES(RES)) i_props (
  .ref_clk(ref_clk), .rst(rst), .scl(scl), .async_update_n(async_update_n), .sda_pull(sda_pull),
  .sda_oe_n(sda_oe_n), .code_a(code_a), .code_b(code_b), .code_c(code_c), .code_d(code_d),
  .chan_powered_down(chan_powered_down), .ext_ref_sel(ext_ref_sel),
  .ref_powered_down(ref_powered_down), .transfer_complete(transfer_complete));
